// file: core/spr_regs.svh
// constants for the shared pause/reset/data-line-three pin logic
// assumes a 40 MHz system clock that oversamples the serial clock pin
`ifndef SPR_REGS_SVH
`define SPR_REGS_SVH

// bit and byte geometry
`define SPR_BYTE_W        8
`define SPR_CNT_W         4
`define SPR_STEP_SINGLE   4'h1
`define SPR_STEP_QUAD     4'h4
`define SPR_CNT_ZERO      4'h0
`define SPR_BYTE_DONE     4'h8
`define SPR_LINE_W        4

// data line positions on the pin group
`define SPR_LINE_IN       0
`define SPR_LINE_OUT      1
`define SPR_LINE_THREE    3

// buffer geometry
`define SPR_FIFO_DEPTH    4

// pin levels: chip select, pause and reset roles are active low
`define SPR_ASSERTED      1'b0
`define SPR_IDLE_LEVEL    1'b1

`endif

// file: core/spr_pkg.sv
// types shared by the shared-pin logic of the serial flash
// assumes the constants header is included by the design file
package spr_pkg;

  // one pin group: four data lines, each with output and enable
  typedef struct packed {
    logic [3:0] o;
    logic [3:0] oe;
  } spr_pins_s;

  // sampled copies of the outside pins after synchronisation
  typedef struct packed {
    logic       cs_b;
    logic       sck;
    logic [3:0] io;
  } spr_samp_s;

  // role the shared pin plays at the moment
  typedef enum logic [1:0] {
    SPR_ROLE_PAUSE,
    SPR_ROLE_RESET,
    SPR_ROLE_DATA
  } spr_role_e;

endpackage

// file: core/spr_pin_ctl.sv
// shared pause/reset/data-line-three pin logic of a serial flash, with its receive buffer
// assumes the host drives chip select, the serial clock and data lines; all pins are oversampled by clk
// Notes on behaviour
// - while paused, serial clock edges and input data are ignored completely
// - while paused, the serial output driver stays high impedance
// - a pause begins only with chip select active and serial clock low
// - pause halts only serial traffic; timed program or erase keeps running
// - quad page program takes four bits per rising edge, line three included
// - quad reads drive line three with lines two to zero on falling edges
// - quad enable clear: status bit selects pause role or reset role
// - quad enable set: pause and reset roles are off, pin carries data
// - quad enable from second status register opens quad transfers on shared lines
// - input captured on rising serial clock edge, output launched on falling edge
`timescale 1ns/1ps
`include "spr_regs.svh"

////////////////////////////////////////////////////////////////////////////////
module spr_fifo #(
  parameter int WIDTH = `SPR_BYTE_W,
  parameter int DEPTH = `SPR_FIFO_DEPTH
) (
  input  wire logic             clk,       // system clock
  input  wire logic             rst_b,     // async reset, active low
  input  wire logic [WIDTH-1:0] in_data,   // word to store
  input  wire logic             in_valid,  // word offered
  output logic                  in_ready,  // room for a word
  output logic      [WIDTH-1:0] out_data,  // oldest word
  output logic                  out_valid, // oldest word present
  input  wire logic             out_ready  // drain side takes the word
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0]      wr_ptr_ff;
  logic [AW:0]      rd_ptr_ff;
  logic [AW:0]      nxt_wr_ptr;
  logic [AW:0]      nxt_rd_ptr;
  logic             push;
  logic             pop;

  always_comb
  begin
    in_ready  = !((wr_ptr_ff[AW] != rd_ptr_ff[AW]) && (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]));
    out_valid = (wr_ptr_ff != rd_ptr_ff);
    out_data  = mem_ff[rd_ptr_ff[AW-1:0]];
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    nxt_wr_ptr = push ? wr_ptr_ff + {{AW{1'b0}}, 1'b1} : wr_ptr_ff;
    nxt_rd_ptr = pop ? rd_ptr_ff + {{AW{1'b0}}, 1'b1} : rd_ptr_ff;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end
    else
    begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
    end
  end

  // storage has no reset; pointers alone define what is valid
  always_ff @(posedge clk)
  begin
    if (push)
      mem_ff[wr_ptr_ff[AW-1:0]] <= in_data;
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module spr_pin_ctl (
  input  wire logic                    clk,             // system clock, 40 MHz
  input  wire logic                    rst_b,           // async reset, active low
  input  wire logic                    cs_b_pin,        // chip select pin, active low
  input  wire logic                    sck_pin,         // serial clock pin
  input  wire logic [`SPR_LINE_W-1:0]  io_in,           // data line levels seen on the pins
  output logic      [`SPR_LINE_W-1:0]  io_out,          // data line drive values
  output logic      [`SPR_LINE_W-1:0]  io_oe,           // data line drive enables, high drives
  input  wire logic                    quad_enable_bit, // quad enable, second status register
  input  wire logic                    reset_role_sel,  // third status register bit 7: 1 selects reset role
  input  wire logic                    quad_prog_cmd,   // quad-input page program data phase
  input  wire logic                    quad_read_cmd,   // quad-output read data phase
  input  wire logic                    timed_op_in,     // program or erase cycle running
  input  wire logic [`SPR_BYTE_W-1:0]  tx_data,         // byte to send to the host
  input  wire logic                    tx_valid,        // tx_data offered
  output logic                         tx_ready,        // pulse: tx_data taken
  output logic      [`SPR_BYTE_W-1:0]  rx_data,         // byte received from the host
  output logic                         rx_valid,        // rx_data present
  input  wire logic                    rx_ready,        // user takes rx_data
  output logic                         rx_overrun,      // sticky: byte lost, buffer full
  output logic                         pause_active,    // pause condition in force
  output logic                         pin_reset,       // reset role asserted on the pin
  output logic                         timed_op_busy    // timed cycle status, untouched by pause
);

  ////////////////////////////////////////////////////////////////////////////////
  // two-stage synchronisers; only the second stage feeds logic
  spr_pkg::spr_samp_s meta_ff;
  spr_pkg::spr_samp_s samp_ff;
  spr_pkg::spr_samp_s prev_ff;
  spr_pkg::spr_samp_s pins_now;
  spr_pkg::spr_samp_s nxt_prev;

  always_comb
  begin
    pins_now = '{cs_b: cs_b_pin, sck: sck_pin, io: io_in};
    nxt_prev = samp_ff;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_ff <= '{cs_b: `SPR_IDLE_LEVEL, sck: 1'b0, io: '1};
      samp_ff <= '{cs_b: `SPR_IDLE_LEVEL, sck: 1'b0, io: '1};
      prev_ff <= '{cs_b: `SPR_IDLE_LEVEL, sck: 1'b0, io: '1};
    end
    else
    begin
      meta_ff <= pins_now;
      samp_ff <= meta_ff;
      prev_ff <= nxt_prev;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // role of the shared pin and the pause condition
  spr_pkg::spr_role_e role;
  logic               selected;
  logic               sck_rise;
  logic               sck_fall;
  logic               pause_ff;
  logic               nxt_pause;
  logic               reset_ff;
  logic               nxt_reset;
  logic               busy_ff;
  logic               nxt_busy;

  always_comb
  begin
    selected = (samp_ff.cs_b == `SPR_ASSERTED);
    sck_rise = samp_ff.sck && !prev_ff.sck;
    sck_fall = !samp_ff.sck && prev_ff.sck;
    if (quad_enable_bit)
      role = spr_pkg::SPR_ROLE_DATA;
    else if (reset_role_sel)
      role = spr_pkg::SPR_ROLE_RESET;
    else
      role = spr_pkg::SPR_ROLE_PAUSE;
    nxt_pause = 1'b0;
    if (role == spr_pkg::SPR_ROLE_PAUSE && selected && samp_ff.io[`SPR_LINE_THREE] == `SPR_ASSERTED)
    begin
      // once begun it lasts while the pin stays low, whatever the clock does
      nxt_pause = pause_ff || !samp_ff.sck;
    end
    nxt_reset = (role == spr_pkg::SPR_ROLE_RESET)
                && (samp_ff.io[`SPR_LINE_THREE] == `SPR_ASSERTED);
    nxt_busy  = timed_op_in;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pause_ff <= 1'b0;
      reset_ff <= 1'b0;
      busy_ff  <= 1'b0;
    end
    else
    begin
      pause_ff <= nxt_pause;
      reset_ff <= nxt_reset;
      busy_ff  <= nxt_busy;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // receive shifter: rising edges only, nothing while paused or reset
  logic                    quad_in;
  logic                    rx_take;
  logic [`SPR_BYTE_W-1:0]  rx_sh_ff;
  logic [`SPR_BYTE_W-1:0]  nxt_rx_sh;
  logic [`SPR_CNT_W-1:0]   rx_cnt_ff;
  logic [`SPR_CNT_W-1:0]   nxt_rx_cnt;
  logic                    push_ff;
  logic                    nxt_push;
  logic [`SPR_BYTE_W-1:0]  push_data_ff;
  logic [`SPR_BYTE_W-1:0]  nxt_push_data;
  logic                    ovr_ff;
  logic                    nxt_ovr;
  logic                    fifo_in_ready;

  always_comb
  begin
    quad_in       = quad_enable_bit && quad_prog_cmd;
    rx_take       = selected && sck_rise && !pause_ff && !nxt_pause && !reset_ff;
    nxt_rx_sh     = rx_sh_ff;
    nxt_rx_cnt    = rx_cnt_ff;
    nxt_push      = 1'b0;
    nxt_push_data = push_data_ff;
    nxt_ovr       = ovr_ff;
    if (!selected || reset_ff)
    begin
      nxt_rx_cnt = `SPR_CNT_ZERO;
    end
    else if (rx_take)
    begin
      if (quad_in)
      begin
        nxt_rx_sh  = {rx_sh_ff[`SPR_BYTE_W-5:0], samp_ff.io};
        nxt_rx_cnt = rx_cnt_ff + `SPR_STEP_QUAD;
      end
      else
      begin
        nxt_rx_sh  = {rx_sh_ff[`SPR_BYTE_W-2:0], samp_ff.io[`SPR_LINE_IN]};
        nxt_rx_cnt = rx_cnt_ff + `SPR_STEP_SINGLE;
      end
      if (nxt_rx_cnt == `SPR_BYTE_DONE)
      begin
        nxt_rx_cnt    = `SPR_CNT_ZERO;
        nxt_push      = 1'b1;
        nxt_push_data = nxt_rx_sh;
      end
    end
    // the host cannot be stalled, so a full buffer drops the byte and says so
    if (push_ff && !fifo_in_ready)
      nxt_ovr = 1'b1;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rx_sh_ff     <= '0;
      rx_cnt_ff    <= `SPR_CNT_ZERO;
      push_ff      <= 1'b0;
      push_data_ff <= '0;
      ovr_ff       <= 1'b0;
    end
    else
    begin
      rx_sh_ff     <= nxt_rx_sh;
      rx_cnt_ff    <= nxt_rx_cnt;
      push_ff      <= nxt_push;
      push_data_ff <= nxt_push_data;
      ovr_ff       <= nxt_ovr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // receive buffer with a registered output stage
  logic [`SPR_BYTE_W-1:0] fifo_out_data;
  logic                   fifo_out_valid;
  logic                   fifo_out_ready;
  logic [`SPR_BYTE_W-1:0] rx_data_ff;
  logic [`SPR_BYTE_W-1:0] nxt_rx_data;
  logic                   rx_valid_ff;
  logic                   nxt_rx_valid;

  spr_fifo #(
    .WIDTH (`SPR_BYTE_W),
    .DEPTH (`SPR_FIFO_DEPTH)
  ) u_rx_fifo (
    .clk       (clk),
    .rst_b     (rst_b),
    .in_data   (push_data_ff),
    .in_valid  (push_ff),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready)
  );

  always_comb
  begin
    fifo_out_ready = !rx_valid_ff || rx_ready;
    nxt_rx_valid   = rx_valid_ff && !rx_ready;
    nxt_rx_data    = rx_data_ff;
    if (fifo_out_ready && fifo_out_valid)
    begin
      nxt_rx_valid = 1'b1;
      nxt_rx_data  = fifo_out_data;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rx_valid_ff <= 1'b0;
      rx_data_ff  <= '0;
    end
    else
    begin
      rx_valid_ff <= nxt_rx_valid;
      rx_data_ff  <= nxt_rx_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // transmit shifter: launches on falling edges, single line or all four
  logic                    quad_out;
  logic                    tx_launch;
  logic [`SPR_BYTE_W-1:0]  tx_sh_ff;
  logic [`SPR_BYTE_W-1:0]  nxt_tx_sh;
  logic [`SPR_CNT_W-1:0]   tx_cnt_ff;
  logic [`SPR_CNT_W-1:0]   nxt_tx_cnt;
  logic                    tx_rdy_ff;
  logic                    nxt_tx_rdy;
  logic                    drive_ff;
  logic                    nxt_drive;
  logic                    quad_drv_ff;
  logic                    nxt_quad_drv;
  spr_pkg::spr_pins_s      pins_ff;
  spr_pkg::spr_pins_s      nxt_pins;

  always_comb
  begin
    quad_out     = quad_enable_bit && quad_read_cmd;
    tx_launch    = selected && sck_fall && !pause_ff && !nxt_pause && !reset_ff;
    nxt_tx_sh    = tx_sh_ff;
    nxt_tx_cnt   = tx_cnt_ff;
    nxt_tx_rdy   = 1'b0;
    nxt_drive    = drive_ff;
    nxt_quad_drv = quad_drv_ff;
    if (!selected || reset_ff)
    begin
      nxt_tx_cnt = `SPR_CNT_ZERO;
      nxt_drive  = 1'b0;
    end
    else if (tx_launch)
    begin
      if (tx_cnt_ff == `SPR_CNT_ZERO)
      begin
        nxt_drive    = tx_valid;
        nxt_quad_drv = quad_out;
        nxt_tx_rdy   = tx_valid;
        nxt_tx_sh    = tx_data;
        nxt_tx_cnt   = tx_valid ? `SPR_BYTE_DONE : `SPR_CNT_ZERO;
      end
      else if (quad_drv_ff)
      begin
        nxt_tx_sh = {tx_sh_ff[`SPR_BYTE_W-5:0], 4'h0};
      end
      else
      begin
        nxt_tx_sh = {tx_sh_ff[`SPR_BYTE_W-2:0], 1'b0};
      end
      // an idle launch keeps the count at zero so the next fall can still load a byte
      if (nxt_drive)
        nxt_tx_cnt = nxt_tx_cnt - (nxt_quad_drv ? `SPR_STEP_QUAD : `SPR_STEP_SINGLE);
    end
    // pins: quad read drives lines three to zero, otherwise only the output line
    nxt_pins.o  = '0;
    nxt_pins.oe = '0;
    if (nxt_quad_drv)
      nxt_pins.o = nxt_tx_sh[`SPR_BYTE_W-1:`SPR_BYTE_W-4];
    else
      nxt_pins.o[`SPR_LINE_OUT] = nxt_tx_sh[`SPR_BYTE_W-1];
    if (nxt_drive && !nxt_pause && !reset_ff)
    begin
      if (nxt_quad_drv)
        nxt_pins.oe = '1;
      else
        nxt_pins.oe[`SPR_LINE_OUT] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tx_sh_ff    <= '0;
      tx_cnt_ff   <= `SPR_CNT_ZERO;
      tx_rdy_ff   <= 1'b0;
      drive_ff    <= 1'b0;
      quad_drv_ff <= 1'b0;
      pins_ff     <= '0;
    end
    else
    begin
      tx_sh_ff    <= nxt_tx_sh;
      tx_cnt_ff   <= nxt_tx_cnt;
      tx_rdy_ff   <= nxt_tx_rdy;
      drive_ff    <= nxt_drive;
      quad_drv_ff <= nxt_quad_drv;
      pins_ff     <= nxt_pins;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flip-flops
  assign io_out        = pins_ff.o;
  assign io_oe         = pins_ff.oe;
  assign tx_ready      = tx_rdy_ff;
  assign rx_data       = rx_data_ff;
  assign rx_valid      = rx_valid_ff;
  assign rx_overrun    = ovr_ff;
  assign pause_active  = pause_ff;
  assign pin_reset     = reset_ff;
  assign timed_op_busy = busy_ff;

endmodule

// file: dv/spr_pin_ctl_asserts.sv
// concurrent checks on the shared pause/reset/data-line-three pin logic
// assumes it is bound to spr_pin_ctl and sees only its ports
`timescale 1ns/1ps
`include "spr_regs.svh"

module spr_pin_ctl_asserts (
  input wire logic                   clk,             // system clock
  input wire logic                   rst_b,           // async reset, active low
  input wire logic                   cs_b_pin,        // chip select pin
  input wire logic                   sck_pin,         // serial clock pin
  input wire logic [`SPR_LINE_W-1:0] io_in,           // data line levels
  input wire logic [`SPR_LINE_W-1:0] io_oe,           // data line enables
  input wire logic                   quad_enable_bit, // quad enable
  input wire logic                   reset_role_sel,  // role select
  input wire logic                   quad_read_cmd,   // quad read phase
  input wire logic                   timed_op_in,     // timed cycle running
  input wire logic                   tx_ready,        // byte taken pulse
  input wire logic [`SPR_BYTE_W-1:0] rx_data,         // received byte
  input wire logic                   rx_valid,        // received byte present
  input wire logic                   rx_ready,        // user takes byte
  input wire logic                   pause_active,    // pause in force
  input wire logic                   pin_reset,       // reset role asserted
  input wire logic                   timed_op_busy    // timed cycle status
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

////////////////////////////////////////
  // enables drop in the same cycle as the pause flag; the check still looks one cycle in
  a_pause_tristate: assert property (pause_active && $past(pause_active) |-> io_oe == 4'h0)
    else $error("data line driven while paused");
  // pins reach the pause flag three edges late through the synchroniser
  a_pause_start: assert property ($rose(pause_active) |-> !$past(cs_b_pin, 3) && !$past(sck_pin, 3))
    else $error("pause began without select or with clock high");
  a_pause_role: assert property ($rose(pause_active) |-> !$past(reset_role_sel) && !$past(quad_enable_bit))
    else $error("pause began in the wrong role");
  a_reset_role: assert property ($rose(pin_reset) |-> $past(reset_role_sel) && !$past(io_in[3], 3))
    else $error("reset role asserted without selection");
  a_quad_off: assert property (quad_enable_bit && $past(quad_enable_bit) |-> !pause_active && !pin_reset)
    else $error("pin role active with quad enabled");
  a_role_low: assert property (io_in[3] [*6] |-> !pause_active && !pin_reset)
    else $error("role asserted with the pin high");
  a_busy_kept: assert property (timed_op_in [*3] |-> timed_op_busy)
    else $error("timed cycle status lost");
  a_tx_single: assert property (tx_ready && !quad_read_cmd |-> io_oe == 4'h2)
    else $error("single output not on line one");
  a_quad_read: assert property (tx_ready && quad_read_cmd && quad_enable_bit |-> io_oe == 4'hF)
    else $error("quad read not driving four lines");
  a_rx_hold: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
    else $error("received byte dropped before taken");
endmodule

bind spr_pin_ctl spr_pin_ctl_asserts u_chk (
  .clk(clk), .rst_b(rst_b), .cs_b_pin(cs_b_pin), .sck_pin(sck_pin), .io_in(io_in), .io_oe(io_oe),
  .quad_enable_bit(quad_enable_bit), .reset_role_sel(reset_role_sel), .quad_read_cmd(quad_read_cmd),
  .timed_op_in(timed_op_in), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
  .rx_ready(rx_ready), .pause_active(pause_active), .pin_reset(pin_reset), .timed_op_busy(timed_op_busy)
);

// file: dv/spr_host_model.sv
// behavioural host controller: chip select, serial clock and data lines
// assumes the bench resolves the shared wires from both drive enables
`timescale 1ns/1ps

module spr_host_model (
  input  wire logic       clk,     // bench clock, phase only
  input  wire logic [3:0] io_w,    // resolved line levels
  output logic            cs_b,    // chip select, active low
  output logic            sck,     // serial clock
  output logic [3:0]      h_out,   // host drive values
  output logic [3:0]      h_oe,    // host drive enables
  output logic            hold_on  // pause held by host
);
  initial
  begin
    cs_b = 1'b1;
    sck = 1'b0;
    h_out = 4'h0;
    h_oe = 4'h0;
    hold_on = 1'b0;
  end

////////////////////////////////////////
  // pulls line three low; active low for both roles
  task drive3(input logic on);
    h_oe[3] = on;
    h_out[3] = 1'b0;
    hold_on = on;
  endtask

  // mode 0 single, 1 quad write, 2 quad read; clock idles high between frames
  task automatic xfer(input logic [7:0] d, input int mode, input int pa, output logic [7:0] got);
    int n;
    n = (mode == 0) ? 8 : 2;
    @(posedge clk);
    #7;
    sck = 1'b1;
    #100;
    cs_b = 1'b0;
    #100;
    h_oe = (mode == 1) ? 4'hF : (mode == 0) ? 4'h1 : 4'h0;
    for (int i = 0; i < n; i++)
    begin
      sck = 1'b0;
      if (mode == 1)
        h_out = d[7-4*i -: 4];
      else
        h_out = {3'h0, d[7-i]};
      #100;
      if (i == pa)
      begin
        drive3(1'b1);
        #400;
        // clock edges and data flips that must be ignored
        repeat (3)
        begin
          sck = 1'b1;
          h_out[0] = ~h_out[0];
          #100;
          sck = 1'b0;
          #100;
        end
        h_out[0] = d[7-i];
        drive3(1'b0);
        #200;
      end
      sck = 1'b1;
      #100;
      if (mode == 2)
        got[7-4*i -: 4] = io_w;
      else
        got[7-i] = io_w[1];
    end
    cs_b = 1'b1;
    h_oe = 4'h0;
    #100;
  endtask
endmodule

// file: dv/spr_pin_ctl_bench.sv
// self-checking bench of the shared pin logic with a host model
// assumes a pull-up on line three; other idle lines toggle every cycle
`timescale 1ns/1ps
`include "spr_regs.svh"

module spr_pin_ctl_bench;
  logic       clk = 1'b0;
  logic       rst_b, cs_b, sck, hold_on, junk;
  logic       qe, sel, qp, qr, top, txv, txr, rxv, rxr, ovr, pa, pr, busy;
  logic [3:0] io_out, io_oe, h_out, h_oe, io_w;
  logic [7:0] txd, rxd, d, t, got;
  int         mismatches = 0;
  int         checks = 0;
  logic [7:0] exp_q[$];

  always #12.5 clk = ~clk;
  always @(posedge clk) junk <= ~junk;
  always @(posedge clk) if (txr === 1'b1) txv <= 1'b0;
  assign io_w = (io_oe & io_out) | (~io_oe & h_oe & h_out) | (~io_oe & ~h_oe & {1'b1, {3{junk}}});

  spr_pin_ctl DUT (
    .clk(clk), .rst_b(rst_b), .cs_b_pin(cs_b), .sck_pin(sck), .io_in(io_w), .io_out(io_out),
    .io_oe(io_oe), .quad_enable_bit(qe), .reset_role_sel(sel), .quad_prog_cmd(qp),
    .quad_read_cmd(qr), .timed_op_in(top), .tx_data(txd), .tx_valid(txv), .tx_ready(txr),
    .rx_data(rxd), .rx_valid(rxv), .rx_ready(rxr), .rx_overrun(ovr), .pause_active(pa),
    .pin_reset(pr), .timed_op_busy(busy)
  );
  spr_host_model host (
    .clk(clk), .io_w(io_w), .cs_b(cs_b), .sck(sck), .h_out(h_out), .h_oe(h_oe), .hold_on(hold_on)
  );

////////////////////////////////////////
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task stop_test;
    $display("mismatches=%0d checks=%0d", mismatches, checks);
    if (mismatches == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task timeout;
    mismatches++;
    $display("CHECK FAILED at %0t: wait ran out", $time);
    stop_test();
  endtask

  // model queue holds every byte that must reach the user side
  task automatic drain;
    int n;
    while (exp_q.size() > 0)
    begin
      n = 0;
      while (rxv !== 1'b1 && n < 200)
      begin
        @(posedge clk);
        #1;
        n++;
      end
      if (n == 200)
        timeout();
      check(rxd, exp_q.pop_front());
      @(posedge clk);
      rxr <= 1'b1;
      @(posedge clk);
      rxr <= 1'b0;
      #1;
    end
  endtask

////////////////////////////////////////
  initial
  begin
    {rst_b, qe, sel, qp, qr, top, txv, rxr, junk} = 9'h0;
    txd = 8'h00;
    d = $urandom(32'hD64DBF9D);
    repeat (16) @(posedge clk);
    check({io_oe, rxd, txr, rxv, ovr, pa, pr, busy}, 16'h0000);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    // full duplex bytes; the sixth finds four words plus output stage full
    for (int k = 0; k < 6; k++)
    begin
      d = $urandom;
      t = $urandom;
      @(posedge clk);
      txd <= t;
      txv <= 1'b1;
      host.xfer(d, 0, -1, got);
      check(got, t);
      if (k < 5)
        exp_q.push_back(d);
      repeat (8) @(posedge clk);
      check(ovr, k == 5);
    end
    drain();
    @(posedge clk);
    qe <= 1'b1;
    qp <= 1'b1;
    repeat (2)
    begin
      d = $urandom;
      host.xfer(d, 1, -1, got);
      exp_q.push_back(d);
    end
    drain();
    t = $urandom;
    @(posedge clk);
    qp <= 1'b0;
    qr <= 1'b1;
    txd <= t;
    txv <= 1'b1;
    host.xfer(8'h00, 2, -1, got);
    check(got, t);
    d = $urandom;
    @(posedge clk);
    {qe, qr, top, txv} <= 4'h3;
    fork
      host.xfer(d, 0, 3, got);
      begin
        for (int i = 0; i < 400 && hold_on !== 1'b1; i++) @(posedge clk);
        if (hold_on !== 1'b1)
          timeout();
        repeat (8) @(posedge clk);
        check({pa, io_oe, busy}, {1'b1, 4'h0, 1'b1});
      end
    join
    check(got, t);
    exp_q.push_back(d);
    drain();
    @(posedge clk);
    top <= 1'b0;
    sel <= 1'b1;
    #1 host.drive3(1'b1);
    repeat (8) @(posedge clk);
    check({pr, pa}, 2'b10);
    qe <= 1'b1;
    repeat (4) @(posedge clk);
    check(pr, 1'b0);
    qe <= 1'b0;
    #1 host.drive3(1'b0);
    repeat (8) @(posedge clk);
    check({pr, pa}, 2'b00);
    stop_test();
  end
endmodule
